// File: motion_io_cfg.svh
/*
 * Register offsets, field positions, reset values and timing figures
 * for the motion task I/O expansion block.
 * Assumes a 32-bit classic Wishbone bus with byte addresses.
 */
`ifndef MOTION_IO_CFG_SVH
`define MOTION_IO_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFF_CTRL 8'h00
`define OFF_EVT 8'h04
`define OFF_TASK 8'h08
`define OFF_STAT 8'h0C
`define OFF_WARN 8'h10
`define OFF_PINS 8'h14
`define OFF_JOG 8'h18
`define OFF_SEQ 8'h1C

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_REF_IGNORE 0
`define CTRL_OUT5_CMP 1
`define CTRL_JOG_EN 2
`define EVT_START 0
`define EVT_NEXT 1
`define EVT_RESUME 2
`define EVT_JOG_GO 3
`define EVT_JOG_STOP 4
`define EVT_CLEAR 5
`define EVT_EARLY 6
`define EVT_W 7
`define STAT_IN_WIN 0
`define WARN_FERR 0
`define WARN_RESP 1
`define SEQ_FIRST 0
`define SEQ_NEXT 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define CTRL_RST 3'h0
`define JOG_RST 16'h0000

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 50
`define ADDR_TIME_NS 4000000
`define START_MAX_NS 2000000
`define OUT_MAX_NS 10000000

`endif

// File: motion_io_pkg.sv
/*
 * Types shared by the motion task I/O expansion block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package motion_io_pkg;
    // jog input handling
    typedef enum logic [0:0] {
        JOG_IDLE,
        JOG_RUN
    } jog_state_t;
endpackage

// File: pin_sampler.sv
/*
 * Pin sampler: registers a group of controller input lines and
 * reports level, rising edge and falling edge per line.
 * Assumes the lines are already synchronous to clk_i.
 */
`timescale 1ns/1ps
module pin_sampler #(
    parameter int W = 14
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] level_o,
    output logic [W-1:0] rise_o,
    output logic [W-1:0] fall_o
);
    logic [W-1:0] prev;

    // ----------------------------------------
    // sample and compare one line at a time
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_line
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    level_o[g] <= 1'b0;
                    prev[g] <= 1'b0;
                end else begin
                    level_o[g] <= pin_i[g];
                    prev[g] <= level_o[g];
                end
            end
            // edges come from flops only, no glitch path from the pin
            assign rise_o[g] = level_o[g] & ~prev[g];
            assign fall_o[g] = ~level_o[g] & prev[g];
        end
    endgenerate
endmodule

// File: motion_io.sv
/*
 * Motion task I/O expansion: fourteen fixed-function controller
 * inputs, eight status outputs (pin 5 switchable to compare 0), a fault lamp, and a
 * classic Wishbone register file for the drive firmware.
 * Assumes pins synchronous to clk_i, 20 MHz, synchronous reset.
 */
`timescale 1ns/1ps
`include "motion_io_cfg.svh"
module motion_io
    import motion_io_pkg::*;
#(
    parameter int ADDR_CYCLES =
        (`ADDR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [7:0] task_select_i,
    input wire logic reference_i,
    input wire logic following_err_clear_i,
    input wire logic next_task_start_i,
    input wire logic jog_i,
    input wire logic task_resume_i,
    input wire logic task_start_i,
    input wire logic out_fault_i,
    output logic target_reached_o,
    output logic sequence_step_o,
    output logic following_err_n_o,
    output logic [5:1] position_compare_o,
    output logic fault_led_o
);
    localparam int CNT_W = $clog2(ADDR_CYCLES + 1);

    // ----------------------------------------
    // input sampling
    // ----------------------------------------
    logic [13:0] lvl;
    logic [13:0] rise;
    logic [13:0] fall;
    logic [7:0] sel_lvl;

    // bits 7:0 task_select_lsb..task_select_msb, then the command lines
    pin_sampler #(
        .W(14)
    ) u_pins (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i({task_start_i, task_resume_i, jog_i, next_task_start_i,
            following_err_clear_i, reference_i, task_select_i}),
        .level_o(lvl),
        .rise_o(rise),
        .fall_o(fall)
    );

    assign sel_lvl = lvl[7:0];
    wire ref_lvl = lvl[8];
    wire clr_rise = rise[9];
    wire next_rise = rise[10];
    wire jog_rise = rise[11];
    wire jog_fall = fall[11];
    wire resume_rise = rise[12];
    wire start_rise = rise[13];

    // ----------------------------------------
    // wishbone slave
    // ----------------------------------------
    logic [2:0] ctrl;
    logic [`EVT_W-1:0] evt;
    logic [7:0] task_num;
    logic [6:0] stat;
    logic [1:0] warn;
    logic [15:0] jog_speed;
    logic [CNT_W-1:0] stable_cnt;
    logic next_pend;
    jog_state_t jog_state;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a[7:2] == off[7:2]);
    endfunction

    wire acc = cyc_i & stb_i & ~ack_o;
    wire wr = cyc_i & stb_i & we_i & ack_o; // lands at the edge the master sees ack
    wire wr_ctrl = wr & hit(adr_i, `OFF_CTRL) & sel_i[0];
    wire wr_evt = wr & hit(adr_i, `OFF_EVT) & sel_i[0];
    wire wr_stat = wr & hit(adr_i, `OFF_STAT) & sel_i[0];
    wire wr_warn = wr & hit(adr_i, `OFF_WARN) & sel_i[0];
    wire wr_seq = wr & hit(adr_i, `OFF_SEQ) & sel_i[0];
    wire ref_eff = ref_lvl & ~ctrl[`CTRL_REF_IGNORE];
    wire jog_rev = jog_speed[15];

    // ack one cycle after request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= acc;
        end
    end

    // read mux, unmapped addresses answer zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (acc && !we_i) begin
            if (hit(adr_i, `OFF_CTRL)) begin
                dat_o <= {29'h0, ctrl};
            end else if (hit(adr_i, `OFF_EVT)) begin
                dat_o <= {25'h0, evt};
            end else if (hit(adr_i, `OFF_TASK)) begin
                dat_o <= {16'h0, sel_lvl, task_num};
            end else if (hit(adr_i, `OFF_STAT)) begin
                dat_o <= {25'h0, stat};
            end else if (hit(adr_i, `OFF_WARN)) begin
                dat_o <= {30'h0, warn};
            end else if (hit(adr_i, `OFF_PINS)) begin
                dat_o <= {28'h0, jog_state == JOG_RUN, out_fault_i, jog_rev,
                    ref_eff};
            end else if (hit(adr_i, `OFF_JOG)) begin
                dat_o <= {16'h0, jog_speed};
            end else begin
                dat_o <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    // control bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= `CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl <= dat_i[2:0];
        end
    end

    // signed jog speed, byte lanes honoured
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            jog_speed <= `JOG_RST;
        end else if (wr && hit(adr_i, `OFF_JOG)) begin
            if (sel_i[0]) begin
                jog_speed[7:0] <= dat_i[7:0];
            end
            if (sel_i[1]) begin
                jog_speed[15:8] <= dat_i[15:8];
            end
        end
    end

    // in-window and compare conditions from the position loop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat <= 7'h00;
        end else if (wr_stat) begin
            stat <= dat_i[6:0];
        end
    end

    // ----------------------------------------
    // warnings
    // ----------------------------------------
    // firmware sets, clear input clears; a set in the same cycle wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            warn <= 2'h0;
        end else begin
            warn <= (warn & {2{~clr_rise}}) | (dat_i[1:0] & {2{wr_warn}});
        end
    end

    // ----------------------------------------
    // task select settling
    // ----------------------------------------
    // cycles since select lines last changed, saturating
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stable_cnt <= '0;
        end else if (rise[7:0] != 8'h00 || fall[7:0] != 8'h00) begin
            stable_cnt <= '0;
        end else if (stable_cnt != CNT_W'(ADDR_CYCLES)) begin
            stable_cnt <= stable_cnt + CNT_W'(1);
        end
    end

    // latch the presented number on start so later changes do no harm
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            task_num <= 8'h00;
        end else if (start_rise) begin
            task_num <= sel_lvl;
        end
    end

    // ----------------------------------------
    // next task gating
    // ----------------------------------------
    // held until the running task is in its window
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            next_pend <= 1'b0;
        end else if (next_pend && stat[`STAT_IN_WIN]) begin
            next_pend <= 1'b0;
        end else if (next_rise) begin
            next_pend <= 1'b1;
        end
    end
    wire next_go = next_pend & stat[`STAT_IN_WIN];

    // ----------------------------------------
    // jog control
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            jog_state <= JOG_IDLE;
        end else begin
            case (jog_state)
                JOG_IDLE: begin
                    if (jog_rise && ctrl[`CTRL_JOG_EN]) begin
                        jog_state <= JOG_RUN;
                    end
                end
                JOG_RUN: begin
                    if (jog_fall || !ctrl[`CTRL_JOG_EN]) begin
                        jog_state <= JOG_IDLE;
                    end
                end
                default: begin
                    jog_state <= JOG_IDLE;
                end
            endcase
        end
    end
    wire jog_go = jog_state == JOG_IDLE && jog_rise && ctrl[`CTRL_JOG_EN];
    wire jog_stop = jog_state == JOG_RUN && jog_fall;

    // ----------------------------------------
    // command events for the firmware
    // ----------------------------------------
    logic [`EVT_W-1:0] evt_set;
    always_comb begin
        evt_set = '0;
        evt_set[`EVT_START] = start_rise;
        evt_set[`EVT_NEXT] = next_go;
        evt_set[`EVT_RESUME] = resume_rise;
        evt_set[`EVT_JOG_GO] = jog_go;
        evt_set[`EVT_JOG_STOP] = jog_stop;
        evt_set[`EVT_CLEAR] = clr_rise;
        evt_set[`EVT_EARLY] = start_rise && stable_cnt != CNT_W'(ADDR_CYCLES);
    end

    // sticky, write one to clear, a new event beats the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt <= '0;
        end else begin
            evt <= (evt & ~(dat_i[`EVT_W-1:0] & {`EVT_W{wr_evt}})) | evt_set;
        end
    end

    // ----------------------------------------
    // status outputs, one flop each
    // ----------------------------------------
    // pure level drive: a broken cable is not seen here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            target_reached_o <= 1'b0;
            position_compare_o <= 5'h00;
            fault_led_o <= 1'b0;
        end else begin
            target_reached_o <= stat[`STAT_IN_WIN];
            position_compare_o <= stat[6:2];
            fault_led_o <= out_fault_i;
        end
    end

    // pin 5 carries compare 0 or the active-low following error
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            following_err_n_o <= 1'b1;
        end else if (ctrl[`CTRL_OUT5_CMP]) begin
            following_err_n_o <= stat[1];
        end else begin
            following_err_n_o <= ~warn[`WARN_FERR];
        end
    end

    // sequence step: low on a SEQ_FIRST write, toggles on each later SEQ_NEXT write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sequence_step_o <= 1'b0;
        end else if (wr_seq && dat_i[`SEQ_FIRST]) begin
            sequence_step_o <= 1'b0;
        end else if (wr_seq && dat_i[`SEQ_NEXT]) begin
            sequence_step_o <= ~sequence_step_o;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_jog_arm;
        ctrl[`CTRL_JOG_EN] && jog_state == JOG_IDLE && jog_rise;
    endsequence
    sequence s_jog_run;
        jog_state == JOG_RUN [*1] ##0 evt[`EVT_JOG_GO];
    endsequence

    a_start_latch: assert property (start_rise |=>
        task_num == $past(sel_lvl) && evt[`EVT_START])
        else $error("task number not latched on start");
    a_next_gate: assert property ($rose(evt[`EVT_NEXT]) && !$past(wr_evt)
        |-> $past(stat[`STAT_IN_WIN]))
        else $error("next task released before target");
    a_jog_start: assert property (s_jog_arm |=> s_jog_run)
        else $error("jog did not start");
    a_jog_stop: assert property (jog_state == JOG_RUN && jog_fall
        |=> jog_state == JOG_IDLE ##0 evt[`EVT_JOG_STOP])
        else $error("jog not cancelled on falling edge");
    a_warn_clear: assert property (clr_rise && !wr_warn |=> warn == 2'h0)
        else $error("warning not cleared");
    a_ferr_low: assert property (!ctrl[`CTRL_OUT5_CMP] [*2]
        |-> following_err_n_o == !$past(warn[`WARN_FERR]))
        else $error("following error output wrong level");
    a_seq_first: assert property (wr_seq && dat_i[`SEQ_FIRST]
        |=> !sequence_step_o)
        else $error("sequence step not low on first task");
    a_seq_toggle: assert property (wr_seq && dat_i[1:0] == 2'b10
        |=> sequence_step_o != $past(sequence_step_o))
        else $error("sequence step did not invert");
    a_in_pos: assert property ($changed(stat[`STAT_IN_WIN])
        |-> ##1 target_reached_o == $past(stat[`STAT_IN_WIN]))
        else $error("target reached output late");
    a_ref_mask: assert property (ctrl[`CTRL_REF_IGNORE] |-> !ref_eff)
        else $error("reference not ignored");
    a_fault_led: assert property (out_fault_i |-> ##[1:2] fault_led_o)
        else $error("fault lamp not lit");
    a_early_flag: assert property (start_rise && stable_cnt == '0
        |=> evt[`EVT_EARLY])
        else $error("unsettled start not flagged");
endmodule

// File: plc_model.sv
/*
 * Controller model: drives the fourteen task control lines the way a
 * PLC output card would, under calls from the testbench.
 * Assumes lines change right after a rising edge of clk_i.
 */
`timescale 1ns/1ps
module plc_model (
    input wire logic clk_i,
    output logic [7:0] task_select_o,
    output logic reference_o,
    output logic following_err_clear_o,
    output logic next_task_start_o,
    output logic jog_o,
    output logic task_resume_o,
    output logic task_start_o
);
    // ----------------------------------------
    // line levels
    // ----------------------------------------
    // every line starts low, as an unpowered output card would
    initial begin
        task_select_o = 8'h00;
        {reference_o, following_err_clear_o, next_task_start_o} = 3'h0;
        {jog_o, task_resume_o, task_start_o} = 3'h0;
    end

    // ----------------------------------------
    // actions
    // ----------------------------------------
    // number in plain binary, bit 0 least significant
    task automatic start_task(input logic [7:0] num, input int settle);
        @(posedge clk_i);
        task_select_o <= num;
        repeat (settle) @(posedge clk_i);
        task_start_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        task_start_o <= 1'b0;
    endtask

    // pulse long enough to be seen after the pin flops
    task automatic pulse(input int line);
        @(posedge clk_i);
        case (line)
            0: next_task_start_o <= 1'b1;
            1: task_resume_o <= 1'b1;
            default: following_err_clear_o <= 1'b1;
        endcase
        repeat (3) @(posedge clk_i);
        {next_task_start_o, task_resume_o, following_err_clear_o} <= 3'h0;
    endtask

    task automatic set_jog(input logic v);
        @(posedge clk_i);
        jog_o <= v;
    endtask

    task automatic set_ref(input logic v);
        @(posedge clk_i);
        reference_o <= v;
    endtask
endmodule

// File: motion_io_tb.sv
/*
 * Self-checking testbench for the motion task I/O block: Wishbone
 * register access plus a controller model on the pin side.
 * Assumes a 50 ns clock and a short address time parameter.
 */
`timescale 1ns/1ps
`include "motion_io_cfg.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module motion_io_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i, stb_i, we_i, out_fault_i;
    logic [7:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, rd;
    logic ack_o, target_reached_o, sequence_step_o, following_err_n_o, fault_led_o;
    logic [5:1] position_compare_o;
    logic [7:0] sel_w;
    logic ref_w, clr_w, next_w, jog_w, res_w, start_w;
    int fail_count = 0, n_compared = 0, cycles = 0;
    logic [31:0] seq_wr [4] = '{32'h2, 32'h1, 32'h2, 32'h2};
    logic seq_exp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

    always #25 clk_i = ~clk_i;

    motion_io #(.ADDR_CYCLES(20)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .task_select_i(sel_w), .reference_i(ref_w),
        .following_err_clear_i(clr_w), .next_task_start_i(next_w), .jog_i(jog_w),
        .task_resume_i(res_w), .task_start_i(start_w), .out_fault_i(out_fault_i),
        .target_reached_o(target_reached_o), .sequence_step_o(sequence_step_o),
        .following_err_n_o(following_err_n_o), .position_compare_o(position_compare_o),
        .fault_led_o(fault_led_o));

    plc_model plc (.clk_i(clk_i), .task_select_o(sel_w), .reference_o(ref_w),
        .following_err_clear_o(clr_w), .next_task_start_o(next_w), .jog_o(jog_w),
        .task_resume_o(res_w), .task_start_o(start_w));

    // ----------------------------------------
    // bus tasks and closing
    // ----------------------------------------
    // hold the request until ack is sampled; a wait that never sees ack ends only at the hang guard
    task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, s};
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rd = dat_o;
        {cyc_i, stb_i, we_i} <= 3'b000;
    endtask

    task automatic wb_write(input logic [7:0] a, input logic [31:0] d);
        wb_cycle(1'b1, a, d, 4'hF);
    endtask

    task automatic wb_read(input logic [7:0] a);
        wb_cycle(1'b0, a, 32'h0, 4'hF);
    endtask

    task automatic settle();
        repeat (6) @(posedge clk_i);
    endtask

    task automatic report_and_stop();
        if (fail_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // hang guard, well above the few hundred cycles the tests need
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {cyc_i, stb_i, we_i, out_fault_i} = 4'h0;
        adr_i = 8'h00;
        sel_i = 4'h0;
        dat_i = 32'h0000_0000;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        `CHK("err_n reset", 1'b1, following_err_n_o)
        `CHK("target reset", 1'b0, target_reached_o)
        wb_read(`OFF_CTRL);
        `CHK("ctrl reset", 32'h0, rd)
        wb_read(`OFF_JOG);
        `CHK("jog reset", 32'h0, rd)
        wb_write(8'h40, 32'hFFFF_FFFF);
        wb_read(8'h40);
        `CHK("unmapped", 32'h0, rd)
        // settled number, then one changed just before start
        plc.start_task(8'hAE, 25);
        settle();
        wb_read(`OFF_EVT);
        `CHK("evt start", 32'h1, rd)
        wb_read(`OFF_TASK);
        `CHK("task 174", 32'hAEAE, rd)
        wb_write(`OFF_EVT, 32'h7F);
        plc.start_task(8'h51, 1);
        settle();
        wb_read(`OFF_EVT);
        `CHK("evt early", 32'h41, rd)
        wb_read(`OFF_TASK);
        `CHK("task 81", 32'h5151, rd)
        wb_write(`OFF_EVT, 32'h7F);
        wb_read(`OFF_EVT);
        `CHK("evt clear", 32'h0, rd)
        // next request held until target reached
        plc.pulse(0);
        settle();
        wb_read(`OFF_EVT);
        `CHK("next held", 32'h0, rd)
        wb_write(`OFF_STAT, 32'h1);
        settle();
        `CHK("target", 1'b1, target_reached_o)
        plc.pulse(1);
        settle();
        wb_read(`OFF_EVT);
        `CHK("next resume", 32'h6, rd)
        wb_write(`OFF_EVT, 32'h7F);
        // jog ignored while disabled, then reverse jog
        plc.set_jog(1'b1);
        settle();
        plc.set_jog(1'b0);
        settle();
        wb_read(`OFF_EVT);
        `CHK("jog off", 32'h0, rd)
        wb_write(`OFF_CTRL, 32'h4);
        wb_write(`OFF_JOG, 32'h8123);
        plc.set_jog(1'b1);
        settle();
        wb_read(`OFF_PINS);
        `CHK("jog pins", 32'hA, rd)
        plc.set_jog(1'b0);
        settle();
        wb_read(`OFF_EVT);
        `CHK("jog evt", 32'h18, rd)
        // low byte lane only: the sign byte must survive
        wb_cycle(1'b1, `OFF_JOG, 32'h0000_7F45, 4'h1);
        wb_read(`OFF_JOG);
        `CHK("jog low lane", 32'h8145, rd)
        // warnings and the clear line
        wb_write(`OFF_WARN, 32'h1);
        settle();
        `CHK("err_n low", 1'b0, following_err_n_o)
        plc.pulse(2);
        settle();
        `CHK("err_n high", 1'b1, following_err_n_o)
        wb_write(`OFF_WARN, 32'h2);
        plc.pulse(2);
        settle();
        wb_read(`OFF_WARN);
        `CHK("warn clear", 32'h0, rd)
        wb_read(`OFF_EVT);
        `CHK("evt clear seen", 32'h38, rd)
        // step output: toggle, first-task low, toggles
        for (int i = 0; i < 4; i++) begin
            wb_write(`OFF_SEQ, seq_wr[i]);
            settle();
            `CHK("seq step", seq_exp[i], sequence_step_o)
        end
        // compare outputs, pin 5 option
        wb_write(`OFF_STAT, 32'h55);
        settle();
        `CHK("compare", 5'h15, position_compare_o)
        wb_write(`OFF_CTRL, 32'h2);
        settle();
        `CHK("pin5 cmp0 lo", 1'b0, following_err_n_o)
        wb_write(`OFF_STAT, 32'h57);
        settle();
        `CHK("pin5 cmp0 hi", 1'b1, following_err_n_o)
        // reference switch, then ignored
        plc.set_ref(1'b1);
        settle();
        wb_read(`OFF_PINS);
        `CHK("ref seen", 32'h3, rd)
        wb_write(`OFF_CTRL, 32'h3);
        wb_read(`OFF_PINS);
        `CHK("ref ignored", 32'h2, rd)
        // a write without lane 0 leaves the control bits alone
        wb_cycle(1'b1, `OFF_CTRL, 32'h0, 4'hE);
        wb_read(`OFF_CTRL);
        `CHK("ctrl lane", 32'h3, rd)
        // output fault lamp
        @(posedge clk_i);
        out_fault_i <= 1'b1;
        settle();
        `CHK("fault led", 1'b1, fault_led_o)
        wb_read(`OFF_PINS);
        `CHK("fault pin", 32'h6, rd)
        report_and_stop();
    end
endmodule
